/* hdl/ach1_pkg.sv */
// Package with the register map, field layout and decode constants of the channel one configuration bank.
`default_nettype none
package ach1_pkg;
    // Control page and register offsets.
    localparam logic [7:0] CFG_PAGE       = 8'h00;
    localparam logic [7:0] SETUP_OFFSET   = 8'h3c;
    localparam logic [7:0] GAIN_OFFSET    = 8'h3d;
    localparam logic [7:0] VOLUME_OFFSET  = 8'h3e;
    localparam logic [7:0] TRIM_OFFSET    = 8'h3f;

    // Reset values.
    localparam logic [7:0] SETUP_RESET    = 8'h00;
    localparam logic [7:0] GAIN_RESET     = 8'h00;
    localparam logic [7:0] VOLUME_RESET   = 8'hc9;
    localparam logic [7:0] TRIM_RESET     = 8'h80;

    // Writable bits of each register; reserved bits are zero here.
    localparam logic [7:0] SETUP_MASK     = 8'hfd;
    localparam logic [7:0] GAIN_MASK      = 8'hfc;
    localparam logic [7:0] VOLUME_MASK    = 8'hff;
    localparam logic [7:0] TRIM_MASK      = 8'hf0;

    // Field positions of the input setup register.
    localparam int KIND_BIT      = 7;
    localparam int SRC_MSB       = 6;
    localparam int SRC_LSB       = 5;
    localparam int COUPLING_BIT  = 4;
    localparam int IMP_MSB       = 3;
    localparam int IMP_LSB       = 2;
    localparam int AGC_EN_BIT    = 0;

    // Field positions of the gain and trim registers.
    localparam int GAIN_MSB      = 7;
    localparam int GAIN_LSB      = 2;
    localparam int TRIM_MSB      = 7;
    localparam int TRIM_LSB      = 4;

    // Mode bit of the global automatic gain control register.
    localparam int AGC_GLOBAL_MODE_BIT = 3;

    // Decode limits.
    localparam logic [5:0] GAIN_MAX_CODE     = 6'h2a;
    localparam logic [7:0] VOLUME_MUTE_CODE  = 8'h00;
    localparam logic [8:0] VOLUME_ZERO_CODE  = 9'h0c9;

    // Input source selection.
    typedef enum logic [1:0] {
        ACH1_SRC_ANA_DIFF,
        ACH1_SRC_ANA_SE,
        ACH1_SRC_PDM,
        ACH1_SRC_RSVD
    } ach1_src_t;

    // Input impedance selection.
    typedef enum logic [1:0] {
        ACH1_IMP_2K5,
        ACH1_IMP_10K,
        ACH1_IMP_20K,
        ACH1_IMP_RSVD
    } ach1_imp_t;

    // One register access from the serial control port.
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] page;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ach1_req_t;
endpackage : ach1_pkg
`default_nettype wire

/* hdl/ach1_field.sv */
// One configuration register with a reset value and a mask of writable bits.
`default_nettype none
module ach1_field #(
    parameter int         W         = 8,
    parameter logic [7:0] RST_VALUE = 8'h00,
    parameter logic [7:0] WR_MASK   = 8'hff
) (
    input  wire logic         core_clk,
    input  wire logic         rst,
    input  wire logic         wr_en,
    input  wire logic [W-1:0] wdata,
    output var  logic [W-1:0] value_ff
);
    logic [W-1:0] nxt_value;

    // Masked bits never store a one, so reserved bits read back as zero.
    always_comb
    begin
        nxt_value = value_ff;
        if (wr_en)
        begin
            nxt_value = wdata & WR_MASK[W-1:0];
        end
    end

    // Synchronous reset to the register's documented value.
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            value_ff <= RST_VALUE[W-1:0] & WR_MASK[W-1:0];
        end
        else
        begin
            value_ff <= nxt_value;
        end
    end
endmodule : ach1_field
`default_nettype wire

/* hdl/ach1_cfg_regs.sv */
// Channel one configuration register bank with decoded, registered settings for the analog and digital paths.
// How it works
// - Bit 7 of the input setup register chooses microphone input at 0 and line input at 1, and resets to 0.
// - Bits 6 to 5 pick analog differential, analog single-ended, PDM microphone, or a reserved code.
// - Bit 4 picks AC coupling at 0 and DC coupling at 1, and matters only on an analog source.
// - Bits 3 to 2 pick about 2.5, 10 or 20 kilohm input impedance, code 3 reserved, analog sources only.
// - Bit 0 enables automatic gain control, which then runs as bit 3 of the global AGC register says.
// - The six gain bits 7 to 2 give code times 1 dB for codes up to 42; higher codes are reserved.
// - Volume code 0 mutes and codes 1 to 255 step 0.5 dB from -100 dB up to 27 dB.
// - The volume register resets to 0xC9, which is 0 dB, and the setup and gain registers to zero.
// - The gain trim register sits at page 0 offset 0x3F and resets to 0x80.
`default_nettype none
module ach1_cfg_regs (
    input  wire logic                core_clk,
    input  wire logic                rst,
    input  wire ach1_pkg::ach1_req_t reg_req,
    input  wire logic [7:0]          agc_global_config_reg,
    output var  logic [7:0]          reg_rdata_ff,
    output var  logic                reg_rvalid_ff,
    output var  logic                input_kind_sel_ff,
    output var  ach1_pkg::ach1_src_t input_source_sel_ff,
    output var  logic                analog_path_ff,
    output var  logic                pdm_path_ff,
    output var  logic                coupling_sel_ff,
    output var  ach1_pkg::ach1_imp_t input_impedance_sel_ff,
    output var  logic                impedance_apply_ff,
    output var  logic                auto_gain_run_ff,
    output var  logic [5:0]          analog_gain_code_ff,
    output var  logic                gain_reserved_ff,
    output var  logic                volume_mute_ff,
    output var  logic signed [8:0]   volume_half_db_ff,
    output var  logic [3:0]          gain_trim_code_ff
);
    logic       page_hit;
    logic       wr_setup;
    logic       wr_gain;
    logic       wr_volume;
    logic       wr_trim;
    logic [7:0] setup_q;
    logic [7:0] gain_q;
    logic [7:0] volume_q;
    logic [7:0] trim_q;
    logic [7:0] nxt_rdata;
    logic       nxt_rvalid;

    logic                nxt_kind;
    ach1_pkg::ach1_src_t nxt_src;
    logic                nxt_analog;
    logic                nxt_pdm;
    logic                nxt_coupling;
    ach1_pkg::ach1_imp_t nxt_imp;
    logic                nxt_imp_apply;
    logic                nxt_agc_run;
    logic [5:0]          nxt_gain;
    logic                nxt_gain_rsvd;
    logic                nxt_mute;
    logic signed [8:0]   nxt_half_db;
    logic [3:0]          nxt_trim;

    // Write strobes per register; other pages never touch this bank.
    assign page_hit  = (reg_req.page == ach1_pkg::CFG_PAGE);
    assign wr_setup  = reg_req.wr && page_hit && (reg_req.addr == ach1_pkg::SETUP_OFFSET);
    assign wr_gain   = reg_req.wr && page_hit && (reg_req.addr == ach1_pkg::GAIN_OFFSET);
    assign wr_volume = reg_req.wr && page_hit && (reg_req.addr == ach1_pkg::VOLUME_OFFSET);
    assign wr_trim   = reg_req.wr && page_hit && (reg_req.addr == ach1_pkg::TRIM_OFFSET);

    // Storage for the four registers; masks keep reserved bits at zero.
    ach1_field #(.W(8), .RST_VALUE(ach1_pkg::SETUP_RESET), .WR_MASK(ach1_pkg::SETUP_MASK)) u_setup (
        .core_clk (core_clk),
        .rst      (rst),
        .wr_en    (wr_setup),
        .wdata    (reg_req.wdata),
        .value_ff (setup_q)
    );
    ach1_field #(.W(8), .RST_VALUE(ach1_pkg::GAIN_RESET), .WR_MASK(ach1_pkg::GAIN_MASK)) u_gain (
        .core_clk (core_clk),
        .rst      (rst),
        .wr_en    (wr_gain),
        .wdata    (reg_req.wdata),
        .value_ff (gain_q)
    );
    ach1_field #(.W(8), .RST_VALUE(ach1_pkg::VOLUME_RESET), .WR_MASK(ach1_pkg::VOLUME_MASK)) u_volume (
        .core_clk (core_clk),
        .rst      (rst),
        .wr_en    (wr_volume),
        .wdata    (reg_req.wdata),
        .value_ff (volume_q)
    );
    ach1_field #(.W(8), .RST_VALUE(ach1_pkg::TRIM_RESET), .WR_MASK(ach1_pkg::TRIM_MASK)) u_trim (
        .core_clk (core_clk),
        .rst      (rst),
        .wr_en    (wr_trim),
        .wdata    (reg_req.wdata),
        .value_ff (trim_q)
    );

    // Read decode; an unmapped address or page answers zero so software never sees stale data.
    always_comb
    begin
        nxt_rvalid = reg_req.rd;
        nxt_rdata  = 8'h00;
        if (!reg_req.rd || !page_hit)
        begin
            nxt_rdata = 8'h00;
        end
        else if (reg_req.addr == ach1_pkg::SETUP_OFFSET)
        begin
            nxt_rdata = setup_q & ach1_pkg::SETUP_MASK;
        end
        else if (reg_req.addr == ach1_pkg::GAIN_OFFSET)
        begin
            nxt_rdata = gain_q & ach1_pkg::GAIN_MASK;
        end
        else if (reg_req.addr == ach1_pkg::VOLUME_OFFSET)
        begin
            nxt_rdata = volume_q;
        end
        else if (reg_req.addr == ach1_pkg::TRIM_OFFSET)
        begin
            nxt_rdata = trim_q & ach1_pkg::TRIM_MASK;
        end
    end

    // Decode of stored settings into the controls that steer the channel.
    always_comb
    begin
        nxt_kind      = setup_q[ach1_pkg::KIND_BIT];
        nxt_src       = ach1_pkg::ach1_src_t'(setup_q[ach1_pkg::SRC_MSB:ach1_pkg::SRC_LSB]);
        nxt_analog    = (nxt_src == ach1_pkg::ACH1_SRC_ANA_DIFF) || (nxt_src == ach1_pkg::ACH1_SRC_ANA_SE);
        nxt_pdm       = (nxt_src == ach1_pkg::ACH1_SRC_PDM);
        // Coupling and impedance are forced to their neutral codes on a non-analog source.
        nxt_coupling  = nxt_analog && setup_q[ach1_pkg::COUPLING_BIT];
        nxt_imp       = ach1_pkg::ach1_imp_t'(setup_q[ach1_pkg::IMP_MSB:ach1_pkg::IMP_LSB]);
        nxt_imp_apply = nxt_analog && (nxt_imp != ach1_pkg::ACH1_IMP_RSVD);
        if (!nxt_analog)
        begin
            nxt_imp = ach1_pkg::ACH1_IMP_2K5;
        end
        nxt_agc_run   = setup_q[ach1_pkg::AGC_EN_BIT] && agc_global_config_reg[ach1_pkg::AGC_GLOBAL_MODE_BIT];
        // A reserved gain code falls back to 0 dB rather than driving an undefined amplifier step.
        nxt_gain      = gain_q[ach1_pkg::GAIN_MSB:ach1_pkg::GAIN_LSB];
        nxt_gain_rsvd = (nxt_gain > ach1_pkg::GAIN_MAX_CODE);
        if (nxt_gain_rsvd)
        begin
            nxt_gain = 6'h00;
        end
        nxt_mute      = (volume_q == ach1_pkg::VOLUME_MUTE_CODE);
        nxt_half_db   = $signed(9'({1'b0, volume_q} - ach1_pkg::VOLUME_ZERO_CODE));
        nxt_trim      = trim_q[ach1_pkg::TRIM_MSB:ach1_pkg::TRIM_LSB];
    end

    // All top outputs are registered; the decode lags a write by one extra cycle.
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            reg_rdata_ff           <= 8'h00;
            reg_rvalid_ff          <= 1'b0;
            input_kind_sel_ff      <= 1'b0;
            input_source_sel_ff    <= ach1_pkg::ACH1_SRC_ANA_DIFF;
            analog_path_ff         <= 1'b1;
            pdm_path_ff            <= 1'b0;
            coupling_sel_ff        <= 1'b0;
            input_impedance_sel_ff <= ach1_pkg::ACH1_IMP_2K5;
            impedance_apply_ff     <= 1'b1;
            auto_gain_run_ff       <= 1'b0;
            analog_gain_code_ff    <= 6'h00;
            gain_reserved_ff       <= 1'b0;
            volume_mute_ff         <= 1'b0;
            volume_half_db_ff      <= 9'sh000;
            gain_trim_code_ff      <= ach1_pkg::TRIM_RESET[ach1_pkg::TRIM_MSB:ach1_pkg::TRIM_LSB];
        end
        else
        begin
            reg_rdata_ff           <= nxt_rdata;
            reg_rvalid_ff          <= nxt_rvalid;
            input_kind_sel_ff      <= nxt_kind;
            input_source_sel_ff    <= nxt_src;
            analog_path_ff         <= nxt_analog;
            pdm_path_ff            <= nxt_pdm;
            coupling_sel_ff        <= nxt_coupling;
            input_impedance_sel_ff <= nxt_imp;
            impedance_apply_ff     <= nxt_imp_apply;
            auto_gain_run_ff       <= nxt_agc_run;
            analog_gain_code_ff    <= nxt_gain;
            gain_reserved_ff       <= nxt_gain_rsvd;
            volume_mute_ff         <= nxt_mute;
            volume_half_db_ff      <= nxt_half_db;
            gain_trim_code_ff      <= nxt_trim;
        end
    end

    // A write of the setup register shows on the input type two cycles later.
    property p_kind_follows_write;
        @(posedge core_clk) disable iff (rst)
        wr_setup |-> ##2 (input_kind_sel_ff == $past(reg_req.wdata[7], 2));
    endproperty
    a_kind_follows_write: assert property (p_kind_follows_write) else $error("input type does not follow write");

    // Source code and the analog or PDM path flags agree.
    property p_source_decode;
        @(posedge core_clk) disable iff (rst)
        ##1 (pdm_path_ff == (input_source_sel_ff == ach1_pkg::ACH1_SRC_PDM))
            && (analog_path_ff == (input_source_sel_ff inside {ach1_pkg::ACH1_SRC_ANA_DIFF, ach1_pkg::ACH1_SRC_ANA_SE}));
    endproperty
    a_source_decode: assert property (p_source_decode) else $error("source decode mismatch");

    // DC coupling is only ever reported on an analog path.
    property p_coupling_analog_only;
        @(posedge core_clk) disable iff (rst)
        coupling_sel_ff |-> analog_path_ff && $past(setup_q[ach1_pkg::COUPLING_BIT]);
    endproperty
    a_coupling_analog_only: assert property (p_coupling_analog_only) else $error("coupling set off analog path");

    // Impedance is applied only on analog sources with a defined code.
    property p_impedance_apply;
        @(posedge core_clk) disable iff (rst)
        impedance_apply_ff |-> analog_path_ff && (input_impedance_sel_ff != ach1_pkg::ACH1_IMP_RSVD);
    endproperty
    a_impedance_apply: assert property (p_impedance_apply) else $error("impedance applied wrongly");

    // Automatic gain runs exactly when enabled and the global mode bit is set.
    property p_agc_run;
        @(posedge core_clk) disable iff (rst)
        ##1 auto_gain_run_ff == ($past(setup_q[ach1_pkg::AGC_EN_BIT])
            && $past(agc_global_config_reg[ach1_pkg::AGC_GLOBAL_MODE_BIT]));
    endproperty
    a_agc_run: assert property (p_agc_run) else $error("agc run flag wrong");

    // A valid gain code passes through and is not flagged as reserved.
    property p_gain_map;
        @(posedge core_clk) disable iff (rst)
        (gain_q[7:2] <= ach1_pkg::GAIN_MAX_CODE) |=> (analog_gain_code_ff == $past(gain_q[7:2])) && !gain_reserved_ff;
    endproperty
    a_gain_map: assert property (p_gain_map) else $error("gain code not mapped");

    // Non-zero volume is unmuted with the half-dB offset from code 201.
    property p_volume_map;
        @(posedge core_clk) disable iff (rst)
        (volume_q != 8'h00) |=> !volume_mute_ff
            && (volume_half_db_ff == $signed(9'({1'b0, $past(volume_q)} - ach1_pkg::VOLUME_ZERO_CODE)));
    endproperty
    a_volume_map: assert property (p_volume_map) else $error("volume decode wrong");

    // Reset values of setup, gain and volume.
    property p_reset_values;
        @(posedge core_clk)
        rst |=> (volume_q == 8'hc9) && (setup_q == 8'h00) && (gain_q == 8'h00);
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("bad reset value");

    // A read of offset 0x3F right after reset returns 0x80.
    property p_trim_reset_read;
        @(posedge core_clk) disable iff (rst)
        ($past(rst) && reg_req.rd && page_hit && (reg_req.addr == 8'h3f) && !$past(wr_trim)) |=> (reg_rdata_ff == 8'h80);
    endproperty
    a_trim_reset_read: assert property (p_trim_reset_read) else $error("trim reset read wrong");

    // Reserved bits of setup, gain and trim always read as zero.
    property p_reserved_zero;
        @(posedge core_clk) disable iff (rst)
        (reg_req.rd && page_hit && (reg_req.addr inside {8'h3c, 8'h3d, 8'h3f}))
            |=> ((reg_rdata_ff & ~(($past(reg_req.addr) == 8'h3c) ? 8'hfd :
                 (($past(reg_req.addr) == 8'h3d) ? 8'hfc : 8'hf0))) == 8'h00);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit read non-zero");
endmodule : ach1_cfg_regs
`default_nettype wire

/* hdl/ach1_cfg_regs_end.sv */
// Holds no logic; the bank lives in ach1_cfg_regs.sv with its register cell in ach1_field.sv.

/* dv/ach1_cfg_regs_test.sv */
// Self-checking testbench for the channel one configuration register bank.
`default_nettype none
`define CHK(act, exp) begin tests_run++; if ((act) !== (exp)) begin errors++; \
    $display("CHECK FAILED at %0t ns: got %h expected %h", $time, (act), (exp)); end end
module ach1_cfg_regs_test;
    timeunit 1ns;
    timeprecision 1ns;

    logic                core_clk;
    logic                rst;
    ach1_pkg::ach1_req_t reg_req;
    logic [7:0]          agc_global_config_reg;
    logic [7:0]          reg_rdata_ff;
    logic                reg_rvalid_ff;
    logic                input_kind_sel_ff;
    ach1_pkg::ach1_src_t input_source_sel_ff;
    logic                analog_path_ff;
    logic                pdm_path_ff;
    logic                coupling_sel_ff;
    ach1_pkg::ach1_imp_t input_impedance_sel_ff;
    logic                impedance_apply_ff;
    logic                auto_gain_run_ff;
    logic [5:0]          analog_gain_code_ff;
    logic                gain_reserved_ff;
    logic                volume_mute_ff;
    logic signed [8:0]   volume_half_db_ff;
    logic [3:0]          gain_trim_code_ff;
    int                  errors;
    int                  tests_run;
    int                  seed;
    logic [7:0]          mdl [4];
    logic [7:0]          wmask [4] = '{8'hfd, 8'hfc, 8'hff, 8'hf0};
    logic [7:0]          rstv [4] = '{8'h00, 8'h00, 8'hc9, 8'h80};
    logic [15:0]         tbl [15] = '{16'h3d03, 16'h3d07, 16'h3dab, 16'h3daf, 16'h3dff, 16'h3e00, 16'h3e01,
                                      16'h3e02, 16'h3ec9, 16'h3eca, 16'h3efe, 16'h3eff, 16'h3f0f, 16'h3fff,
                                      16'h3f7a};

    ach1_cfg_regs ach1_cfg_regs_i (
        .core_clk(core_clk), .rst(rst), .reg_req(reg_req), .agc_global_config_reg(agc_global_config_reg),
        .reg_rdata_ff(reg_rdata_ff), .reg_rvalid_ff(reg_rvalid_ff), .input_kind_sel_ff(input_kind_sel_ff),
        .input_source_sel_ff(input_source_sel_ff), .analog_path_ff(analog_path_ff), .pdm_path_ff(pdm_path_ff),
        .coupling_sel_ff(coupling_sel_ff), .input_impedance_sel_ff(input_impedance_sel_ff),
        .impedance_apply_ff(impedance_apply_ff), .auto_gain_run_ff(auto_gain_run_ff),
        .analog_gain_code_ff(analog_gain_code_ff), .gain_reserved_ff(gain_reserved_ff),
        .volume_mute_ff(volume_mute_ff), .volume_half_db_ff(volume_half_db_ff),
        .gain_trim_code_ff(gain_trim_code_ff)
    );

    // The clock runs at 10 MHz.
    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // Model view of a read: only page 0 offsets 0x3C to 0x3F hold data.
    function automatic logic [7:0] mdl_read(input logic [7:0] p, input logic [7:0] a);
        mdl_read = 8'h00;
        if (p == 8'h00 && a >= 8'h3c && a <= 8'h3f)
            mdl_read = mdl[a[1:0]];
    endfunction : mdl_read

    // One bus cycle, driven once per falling edge so back-to-back accesses never collide.
    task automatic access(input logic w, input logic r, input logic [7:0] p, input logic [7:0] a,
                          input logic [7:0] d);
        @(negedge core_clk);
        reg_req = '{wr: w, rd: r, page: p, addr: a, wdata: d};
        if (w && p == 8'h00 && a >= 8'h3c && a <= 8'h3f)
            mdl[a[1:0]] = d & wmask[a[1:0]];
    endtask : access

    // Read with the answer taken exactly one cycle after the strobe.
    task automatic rd_chk(input logic [7:0] p, input logic [7:0] a);
        logic [7:0] exp_data;
        exp_data = mdl_read(p, a);
        access(1'b0, 1'b1, p, a, 8'h00);
        access(1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
        `CHK(reg_rvalid_ff, 1'b1)
        `CHK(reg_rdata_ff, exp_data)
    endtask : rd_chk

    // Leaves reset and reads the trim register at the very first edge out of reset.
    task automatic release_chk;
        logic [7:0] exp_data;
        exp_data = mdl_read(8'h00, 8'h3f);
        @(negedge core_clk);
        rst = 1'b0;
        reg_req = '{wr: 1'b0, rd: 1'b1, page: 8'h00, addr: 8'h3f, wdata: 8'h00};
        access(1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
        `CHK(reg_rvalid_ff, 1'b1)
        `CHK(reg_rdata_ff, exp_data)
    endtask : release_chk

    // Decoded settings are compared two cycles after the last write.
    task automatic dec_chk;
        logic [1:0]        src;
        logic              ana;
        logic [5:0]        g;
        logic signed [8:0] hdb;
        access(1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
        access(1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
        src = mdl[0][6:5];
        ana = (src < 2'h2);
        g = mdl[1][7:2];
        hdb = $signed({1'b0, mdl[2]}) - $signed(9'h0c9);
        // With no read in flight the read port must be quiet and answer zero.
        `CHK(reg_rvalid_ff, 1'b0)
        `CHK(reg_rdata_ff, 8'h00)
        `CHK(input_kind_sel_ff, mdl[0][7])
        `CHK(input_source_sel_ff, src)
        `CHK(analog_path_ff, ana)
        `CHK(pdm_path_ff, src == 2'h2)
        `CHK(coupling_sel_ff, mdl[0][4] & ana)
        `CHK(input_impedance_sel_ff, ana ? mdl[0][3:2] : 2'h0)
        `CHK(impedance_apply_ff, ana && mdl[0][3:2] != 2'h3)
        `CHK(auto_gain_run_ff, mdl[0][0] & agc_global_config_reg[3])
        `CHK(analog_gain_code_ff, (g <= 6'h2a) ? g : 6'h00)
        `CHK(gain_reserved_ff, g > 6'h2a)
        `CHK(volume_mute_ff, mdl[2] == 8'h00)
        `CHK(volume_half_db_ff, hdb)
        `CHK(gain_trim_code_ff, mdl[3][7:4])
    endtask : dec_chk

    // Reset value check of every register and its decoded outputs.
    task automatic reset_chk;
        for (int k = 0; k < 4; k++)
            rd_chk(8'h00, 8'h3c + 8'(k));
        dec_chk;
    endtask : reset_chk

    // Prints the counts and the verdict, then ends the run.
    task automatic summarize;
        $display("Comparisons: %0d, mismatches: %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : summarize

    // A hung run is cut short and counted as a mismatch.
    initial
    begin
        repeat (50000) @(posedge core_clk);
        errors++;
        summarize;
    end

    // Main sequence.
    initial
    begin
        logic [7:0] old_data;
        seed = 32'h102e;
        errors = 0;
        tests_run = 0;
        rst = 1'b1;
        reg_req = '0;
        agc_global_config_reg = 8'h00;
        for (int k = 0; k < 4; k++)
            mdl[k] = rstv[k];
        repeat (15) @(negedge core_clk);
        release_chk;
        reset_chk;
        // Every source, impedance, coupling and AGC code; bit 1 is always written high to prove it is dropped.
        // Pin setup for analog or PDM sources is software's job outside this block.
        for (int s = 0; s < 4; s++)
            for (int i = 0; i < 4; i++)
            begin
                access(1'b1, 1'b0, 8'h00, 8'h3c, {s[0] ^ i[0], s[1:0], i[0], i[1:0], 1'b1, ~i[1]});
                agc_global_config_reg = 8'($random(seed));
                dec_chk;
                rd_chk(8'h00, 8'h3c);
            end
        // Gain, volume and trim boundary codes, reserved bits set.
        for (int k = 0; k < 15; k++)
        begin
            access(1'b1, 1'b0, 8'h00, tbl[k][15:8], tbl[k][7:0]);
            dec_chk;
            rd_chk(8'h00, tbl[k][15:8]);
        end
        // Writes to other pages and offsets must leave the bank alone and read back as zero.
        access(1'b1, 1'b0, 8'h01, 8'h3c, 8'hff);
        access(1'b1, 1'b0, 8'h00, 8'h3b, 8'hff);
        access(1'b1, 1'b0, 8'h00, 8'h40, 8'hff);
        rd_chk(8'h01, 8'h3e);
        rd_chk(8'h00, 8'h40);
        dec_chk;
        // Back-to-back writes, then a write and read together that must return the old value.
        access(1'b1, 1'b0, 8'h00, 8'h3e, 8'h55);
        access(1'b1, 1'b0, 8'h00, 8'h3e, 8'haa);
        old_data = mdl_read(8'h00, 8'h3e);
        access(1'b1, 1'b1, 8'h00, 8'h3e, 8'h12);
        access(1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
        `CHK(reg_rdata_ff, old_data)
        rd_chk(8'h00, 8'h3e);
        // Random traffic over mapped and unmapped places.
        for (int n = 0; n < 300; n++)
        begin
            if ($random(seed) & 1)
                rd_chk((($random(seed) & 3) == 0) ? 8'h01 : 8'h00, 8'h3a + 8'($random(seed) & 7));
            else
                access(1'b1, 1'b0, (($random(seed) & 3) == 0) ? 8'h01 : 8'h00, 8'h3a + 8'($random(seed) & 7),
                       8'($random(seed)));
            agc_global_config_reg = 8'($random(seed));
            dec_chk;
        end
        // A second reset in mid-run restores every register.
        rst = 1'b1;
        access(1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
        for (int k = 0; k < 4; k++)
            mdl[k] = rstv[k];
        release_chk;
        reset_chk;
        summarize;
    end
endmodule : ach1_cfg_regs_test
`default_nettype wire
